// >>> ecl_ahb_host.sv
// ahb-lite master model: single word transfers, waits on hready
`timescale 1ns/1ps

module ecl_ahb_host (
   // clock and answer
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // request
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   // set once a wait ran out of its bound
   output logic             tmo
);
   // idle bus at time zero
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'b010;
      hwdata = 32'h0;
      tmo    = 1'b0;
   end

   // bounded wait for hready at a rising edge
   task wait_ready;
      int n;
      for (n = 0; n < 16; n++) begin
         @(posedge hclk);
         if (hready === 1'b1) break;
      end
      if (n == 16) tmo = 1'b1;
   endtask : wait_ready

   // one transfer; released haddr and hwdata show an inverse value, hwrite keeps its old value
   task access(input logic wr, input logic [31:0] a, input logic [31:0] d,
               output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      wait_ready;
      hsel   <= 1'b0;
      htrans <= 2'b00;
      haddr  <= ~a;
      hwdata <= wr ? d : ~hwdata;
      wait_ready;
      q = hrdata;
      hwdata <= ~d;
   endtask : access
endmodule : ecl_ahb_host

// >>> ecl_defs.svh
// constants for the configuration preset loader: offsets, fields, defaults
`ifndef ECL_DEFS_SVH
`define ECL_DEFS_SVH

// register indices; byte address is four times the index
`define ECL_IDX_P1_SLOT   8'h62
`define ECL_IDX_P2_SLOT   8'h64
`define ECL_IDX_P0_TL     8'h68
`define ECL_IDX_P1_TL     8'h6A
`define ECL_IDX_P2_TL     8'h6C
`define ECL_IDX_CTRL      8'h00
`define ECL_IDX_STATUS    8'h01

// preset word reset values
`define ECL_DEF_P1_SLOT   16'h0012
`define ECL_DEF_P2_SLOT   16'h0022
`define ECL_DEF_P0_TL     16'h0376
`define ECL_DEF_P1_TL     16'h0370
`define ECL_DEF_P2_TL     16'h0370

// number of preset words walked by the loader
`define ECL_WORD_CNT      5

// slot preset word source bit positions
`define ECL_SL_IMPL       0
`define ECL_SL_CONN_CLK   1
`define ECL_SL_INIT_REQ   2
`define ECL_SL_LPVC       3
`define ECL_SL_PNUM_LO    4
`define ECL_SL_PNUM_HI    6
`define ECL_SL_TCMAP_LO   9
`define ECL_SL_TCMAP_HI   15

// transaction preset word source bit positions
`define ECL_TL_PORT_DIS   0
`define ECL_TL_RST_SEL    1
`define ECL_TL_CLK_PM     2
`define ECL_TL_PM_L11     4
`define ECL_TL_APM_L11    5
`define ECL_TL_L1SS       6
`define ECL_TL_ARB_MODE   8
`define ECL_TL_GNT_MODE   9

// control and status fields
`define ECL_CTRL_RELOAD   0
`define ECL_STAT_DONE     0
`define ECL_STAT_BUSY     1

`endif

// >>> ecl_loader.sv
// configuration preset loader with an AHB-Lite register slave
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "ecl_defs.svh"

module ecl_loader
   import ecl_pkg::*;
#(
   parameter int WORD_W = 16,   // preset word width
   parameter int ADDR_W = 12    // decoded address bits
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave request
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   // ahb-lite slave answer
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // slot images for ports 1 and 2
   output ecl_slot_cfg_t    p1_slot_cfg,
   output ecl_slot_cfg_t    p2_slot_cfg,
   // transaction-layer images for ports 0 to 2
   output ecl_tl_cfg_t      p0_tl_cfg,
   output ecl_tl_cfg_t      p1_tl_cfg,
   output ecl_tl_cfg_t      p2_tl_cfg,
   // all images applied; ports may take config traffic
   output logic             cfg_ready
);

   // the walk visits each preset word once; a new word means growing
   // this count, the slot decode and the apply strobes together
   localparam int NW = `ECL_WORD_CNT;   // preset words held

   // only ADDR_W address bits are decoded, so the map repeats above them
   // byte address of a register from its index
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = ADDR_W'({idx, 2'b00});
   endfunction : reg_addr

   // preset slot number of an address; NW when it is no preset
   function automatic logic [2:0] preset_slot(
      input logic [ADDR_W-1:0] a);
      preset_slot = (a == reg_addr(`ECL_IDX_P1_SLOT)) ? 3'h0 :
                    (a == reg_addr(`ECL_IDX_P2_SLOT)) ? 3'h1 :
                    (a == reg_addr(`ECL_IDX_P0_TL))   ? 3'h2 :
                    (a == reg_addr(`ECL_IDX_P1_TL))   ? 3'h3 :
                    (a == reg_addr(`ECL_IDX_P2_TL))   ? 3'h4 :
                                                        3'(NW);
   endfunction : preset_slot

   // reset values of the preset words, in slot order
   localparam logic [WORD_W-1:0] DEF [NW] = '{
      WORD_W'(`ECL_DEF_P1_SLOT), WORD_W'(`ECL_DEF_P2_SLOT),
      WORD_W'(`ECL_DEF_P0_TL),   WORD_W'(`ECL_DEF_P1_TL),
      WORD_W'(`ECL_DEF_P2_TL)};

   // ------------------------------------------------------------------
   // bus state
   // ------------------------------------------------------------------
   logic [ADDR_W-1:0] addr_q;       // address of the pending data phase
   logic              wr_q;         // write data phase pending
   logic              rd_q;         // read data phase, wait cycle
   logic              hreadyout_q;  // ready answer
   logic [31:0]       hrdata_q;     // read answer

   // preset storage, one word per slot
   logic [WORD_W-1:0] preset_q [NW];

   // sequencer state
   ecl_state_t        state_q;      // loader state
   ecl_state_t        state_d;      // next loader state
   logic [2:0]        idx_q;        // word being applied
   logic [2:0]        idx_d;        // next word
   logic              ready_q;      // images valid
   logic              ready_d;      // next ready

   // applied images
   ecl_slot_cfg_t     slot_q [2];   // ports 1 and 2
   ecl_tl_cfg_t       tl_q   [3];   // ports 0, 1 and 2

   // decoder outputs
   ecl_slot_cfg_t     slot_dec [2]; // decoded slot words
   ecl_tl_cfg_t       tl_dec   [3]; // decoded transaction words

   // ------------------------------------------------------------------
   // address phase and data phase decode
   // ------------------------------------------------------------------
   // a transfer is taken only when the previous data phase has ended
   wire               addr_ph   = hsel & htrans[1] & hready;
   wire [ADDR_W-1:0]  addr_in   = haddr[ADDR_W-1:0];
   wire [2:0]         wr_slot   = preset_slot(addr_q);
   // writes to unmapped places are dropped, still with an OKAY answer
   wire               wr_preset = wr_q & (wr_slot != 3'(NW));
   wire               wr_ctrl   = wr_q &
                                  (addr_q == reg_addr(`ECL_IDX_CTRL));
   // reload request: a one written to the control word
   wire               reload    = wr_ctrl & hwdata[`ECL_CTRL_RELOAD];
   wire               busy      = (state_q == ECL_ST_WALK);

   // read selection; presets sit in the low bits, the rest reads zero
   wire [2:0]         rd_slot   = preset_slot(addr_q);
   wire               rd_stat   = (addr_q ==
                                   reg_addr(`ECL_IDX_STATUS));
   // status: bit 1 busy while walking, bit 0 done once all are applied
   wire [31:0]        stat_word = {30'h0, busy, ready_q};
   wire [31:0]        rd_word   =
      (rd_slot != 3'(NW)) ? {{(32-WORD_W){1'b0}}, preset_q[rd_slot]} :
      rd_stat             ? stat_word :
                            32'h0000_0000;

   // address phase capture; the master holds its request while we wait
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= '0;
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
      end else begin
         if (addr_ph) begin
            addr_q <= addr_in;
         end
         wr_q <= addr_ph & hwrite;
         rd_q <= addr_ph & ~hwrite;
      end
   end

   // reads take one wait cycle so a write just before is always seen
   // trade-off: a wait cycle per read buys a fully registered hrdata
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
         hrdata_q    <= 32'h0000_0000;
      end else begin
         hreadyout_q <= ~(addr_ph & ~hwrite);
         if (rd_q) begin
            hrdata_q <= rd_word;
         end
      end
   end

   // preset words: software may replace any word; takes effect on load
   // nothing downstream sees a preset until the next walk copies it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NW; i++) begin
            preset_q[i] <= DEF[i];
         end
      end else if (wr_preset) begin
         preset_q[wr_slot] <= hwdata[WORD_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // word decoders
   // ------------------------------------------------------------------
   // port 1 slot word
   ecl_slot_map #(
      .WORD_W (WORD_W)
   ) u_p1_slot (
      .word (preset_q[0]),
      .cfg  (slot_dec[0])
   );

   // port 2 slot word, same layout
   ecl_slot_map #(
      .WORD_W (WORD_W)
   ) u_p2_slot (
      .word (preset_q[1]),
      .cfg  (slot_dec[1])
   );

   ecl_tl_map #(
      .WORD_W (WORD_W)
   ) u_p0_tl (
      .word (preset_q[2]),
      .cfg  (tl_dec[0])
   );

   ecl_tl_map #(
      .WORD_W (WORD_W)
   ) u_p1_tl (
      .word (preset_q[3]),
      .cfg  (tl_dec[1])
   );

   ecl_tl_map #(
      .WORD_W (WORD_W)
   ) u_p2_tl (
      .word (preset_q[4]),
      .cfg  (tl_dec[2])
   );

   // ------------------------------------------------------------------
   // load sequencer
   // ------------------------------------------------------------------
   // walks the words one per cycle; a reload restarts the walk so a
   // word changed mid-walk is never left half applied
   // limitation: reloads every few cycles can hold the walk off
   always_comb begin
      state_d = state_q;
      idx_d   = idx_q;
      ready_d = ready_q;
      unique case (state_q)
         // waiting for a reload request
         ECL_ST_IDLE, ECL_ST_DONE: begin
            if (reload) begin
               state_d = ECL_ST_WALK;
               idx_d   = 3'h0;
               ready_d = 1'b0;
            end
         end
         // applying word idx_q this cycle
         ECL_ST_WALK: begin
            if (reload) begin
               // restart: words already applied are applied again
               idx_d   = 3'h0;
            end else if (idx_q == 3'(NW - 1)) begin
               state_d = ECL_ST_DONE;
               ready_d = 1'b1;
            end else begin
               idx_d   = idx_q + 3'h1;
            end
         end
         // unused code: recover by walking again
         default: begin
            state_d = ECL_ST_WALK;
            idx_d   = 3'h0;
            ready_d = 1'b0;
         end
      endcase
   end

   // walk starts by itself on reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ECL_ST_WALK;
         idx_q   <= 3'h0;
         ready_q <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q   <= idx_d;
         ready_q <= ready_d;
      end
   end

   // which image the current walk step writes
   // one strobe per step, so each image loads exactly once a walk
   wire apply_slot0 = busy & (idx_q == 3'h0);
   wire apply_slot1 = busy & (idx_q == 3'h1);
   wire apply_tl0   = busy & (idx_q == 3'h2);
   wire apply_tl1   = busy & (idx_q == 3'h3);
   wire apply_tl2   = busy & (idx_q == 3'h4);

   // slot images; zero until the first walk has written them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slot_q[0] <= '0;
         slot_q[1] <= '0;
      end else begin
         if (apply_slot0) begin
            slot_q[0] <= slot_dec[0];
         end
         if (apply_slot1) begin
            slot_q[1] <= slot_dec[1];
         end
      end
   end

   // transaction-layer images
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tl_q[0] <= '0;
         tl_q[1] <= '0;
         tl_q[2] <= '0;
      end else begin
         if (apply_tl0) begin
            tl_q[0] <= tl_dec[0];
         end
         if (apply_tl1) begin
            tl_q[1] <= tl_dec[1];
         end
         if (apply_tl2) begin
            tl_q[2] <= tl_dec[2];
         end
      end
   end

   // ------------------------------------------------------------------
   // outputs, all straight from flops except hresp, which is tied low
   // ------------------------------------------------------------------
   assign hreadyout   = hreadyout_q;
   assign hresp       = 1'b0;           // always OKAY
   assign hrdata      = hrdata_q;
   assign p1_slot_cfg = slot_q[0];
   assign p2_slot_cfg = slot_q[1];
   assign p0_tl_cfg   = tl_q[0];
   assign p1_tl_cfg   = tl_q[1];
   assign p2_tl_cfg   = tl_q[2];
   // images read zero until the first walk; cfg_ready qualifies them
   assign cfg_ready   = ready_q;

endmodule : ecl_loader

// >>> ecl_loader_monitor.sv
// bus and load-sequence assertions for the configuration preset loader
`timescale 1ns/1ps

module ecl_loader_monitor
   import ecl_pkg::*;
(
   // clock and reset
   input wire logic          hclk,
   input wire logic          hresetn,
   // bus request as seen by the slave
   input wire logic          hsel,
   input wire logic [31:0]   haddr,
   input wire logic [1:0]    htrans,
   input wire logic          hwrite,
   input wire logic [31:0]   hwdata,
   input wire logic          hready,
   // bus answer
   input wire logic          hreadyout,
   input wire logic          hresp,
   input wire logic [31:0]   hrdata,
   // applied images
   input wire ecl_slot_cfg_t p1_slot_cfg,
   input wire ecl_slot_cfg_t p2_slot_cfg,
   input wire ecl_tl_cfg_t   p0_tl_cfg,
   input wire ecl_tl_cfg_t   p1_tl_cfg,
   input wire ecl_tl_cfg_t   p2_tl_cfg,
   input wire logic          cfg_ready
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // accepted address phases
   wire logic        take   = hsel & htrans[1] & hready;
   wire logic        rd_tk  = take & ~hwrite;
   wire logic        wr_tk  = take & hwrite;
   // control register sits at byte address zero
   wire logic        ctl_tk = wr_tk & (haddr[11:0] == 12'h000);
   // all images in one vector; at 50 bits it drops slot_impl and conn_clock of p1_slot_cfg
   wire logic [49:0] images = {p1_slot_cfg, p2_slot_cfg, p0_tl_cfg,
                               p1_tl_cfg, p2_tl_cfg};

   property p_resp_okay;       hresp == 1'b0; endproperty
   property p_read_wait;       rd_tk |=> !hreadyout ##1 hreadyout; endproperty
   property p_write_zero_wait; wr_tk |=> hreadyout; endproperty
   property p_rdata_hold;
      hreadyout && $past(hreadyout) |-> $stable(hrdata);
   endproperty
   // walk of five words starts at the first edge after release
   property p_walk_after_reset;
      $rose(hresetn) |-> !cfg_ready [*5] ##1 cfg_ready;
   endproperty
   property p_reload_drops;    ctl_tk ##1 hwdata[0] |=> !cfg_ready; endproperty
   property p_walk_length;
      $fell(cfg_ready) |-> !cfg_ready [*5] ##1 cfg_ready;
   endproperty
   // images only move while a walk is in flight
   property p_images_hold;
      cfg_ready && $past(cfg_ready) |-> $stable(images);
   endproperty

   a_resp_okay: assert property (p_resp_okay)
      else $error("hresp not okay");
   a_read_wait: assert property (p_read_wait)
      else $error("read did not take one wait state");
   a_write_zero_wait: assert property (p_write_zero_wait)
      else $error("write data phase stalled");
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("hrdata moved outside a read answer");
   a_walk_after_reset: assert property (p_walk_after_reset)
      else $error("cfg_ready timing after reset wrong");
   a_reload_drops: assert property (p_reload_drops)
      else $error("cfg_ready did not drop on reload");
   a_walk_length: assert property (p_walk_length)
      else $error("walk length wrong");
   a_images_hold: assert property (p_images_hold)
      else $error("images changed while ready");

   c_read:   cover property (rd_tk);
   c_reload: cover property (ctl_tk ##1 hwdata[0]);
   c_done:   cover property ($rose(cfg_ready));
endmodule : ecl_loader_monitor

bind ecl_loader ecl_loader_monitor u_mon (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .hreadyout, .hresp, .hrdata, .p1_slot_cfg, .p2_slot_cfg, .p0_tl_cfg,
   .p1_tl_cfg, .p2_tl_cfg, .cfg_ready
);

// >>> ecl_pkg.sv
// types shared by the configuration preset loader
package ecl_pkg;

   // per-port slot image: destination fields of one slot preset word
   typedef struct packed {
      logic       slot_impl;    // slot implemented
      logic       conn_clock;   // runs from connector clock
      logic       init_req;     // device specific init needed
      logic       lpvc;         // channel 1 in low-priority group
      logic [2:0] port_num;     // logical port number
      logic [6:0] tc_vc0_map;   // traffic classes mapped to channel 0
   } ecl_slot_cfg_t;

   // per-port transaction-layer image
   typedef struct packed {
      logic port_dis;                  // port disable
      logic reset_sel;                 // reset select
      logic clk_pm_cap;                // clock power-management capable
      logic pm_l11_support;            // L1.1 under pci pm
      logic active_pm_l11_support;     // L1.1 under active-state pm
      logic l1_substate_support;       // L1 substates supported
      logic channel_arbitration_mode;  // channel arbitration mode
      logic grant_fail_mode;           // grant failure mode
   } ecl_tl_cfg_t;

   // loader sequencer states
   typedef enum logic [1:0] {
      ECL_ST_IDLE = 2'b00,
      ECL_ST_WALK = 2'b01,
      ECL_ST_DONE = 2'b10
   } ecl_state_t;

endpackage : ecl_pkg

// >>> ecl_slot_map.sv
// maps one slot preset word onto its port's slot configuration fields
`timescale 1ns/1ps
`include "ecl_defs.svh"

module ecl_slot_map
   import ecl_pkg::*;
#(
   parameter int WORD_W = 16
) (
   // preset word in
   input  wire logic [WORD_W-1:0] word,
   // decoded image out
   output ecl_slot_cfg_t          cfg
);

   assign cfg.slot_impl  = word[`ECL_SL_IMPL];
   assign cfg.conn_clock = word[`ECL_SL_CONN_CLK];
   assign cfg.init_req   = word[`ECL_SL_INIT_REQ];
   assign cfg.lpvc       = word[`ECL_SL_LPVC];
   assign cfg.port_num   = word[`ECL_SL_PNUM_HI:`ECL_SL_PNUM_LO];
   assign cfg.tc_vc0_map = word[`ECL_SL_TCMAP_HI:`ECL_SL_TCMAP_LO];

endmodule : ecl_slot_map

// >>> ecl_tl_map.sv
// maps one transaction preset word onto its port's control fields
`timescale 1ns/1ps
`include "ecl_defs.svh"

module ecl_tl_map
   import ecl_pkg::*;
#(
   parameter int WORD_W = 16
) (
   // preset word in
   input  wire logic [WORD_W-1:0] word,
   // decoded image out
   output ecl_tl_cfg_t            cfg
);

   assign cfg.port_dis                 = word[`ECL_TL_PORT_DIS];
   assign cfg.reset_sel                = word[`ECL_TL_RST_SEL];
   assign cfg.clk_pm_cap               = word[`ECL_TL_CLK_PM];
   assign cfg.pm_l11_support           = word[`ECL_TL_PM_L11];
   assign cfg.active_pm_l11_support    = word[`ECL_TL_APM_L11];
   assign cfg.l1_substate_support      = word[`ECL_TL_L1SS];
   assign cfg.channel_arbitration_mode = word[`ECL_TL_ARB_MODE];
   assign cfg.grant_fail_mode          = word[`ECL_TL_GNT_MODE];

endmodule : ecl_tl_map

// >>> tb_ecl_loader.sv
// self-checking bench for the configuration preset loader
`timescale 1ns/1ps
`include "ecl_defs.svh"

module tb_ecl_loader
   import ecl_pkg::*;
;
   logic              hclk = 1'b0;
   logic              hresetn = 1'b0;
   wire logic         hsel, hwrite, tmo;
   wire logic [31:0]  haddr, hwdata;
   wire logic [1:0]   htrans;
   wire logic [2:0]   hsize;
   logic              hreadyout, hresp, cfg_ready;
   logic [31:0]       hrdata;
   ecl_slot_cfg_t     p1_slot_cfg, p2_slot_cfg;
   ecl_tl_cfg_t       p0_tl_cfg, p1_tl_cfg, p2_tl_cfg;
   int                err_count = 0;
   int                num_checks = 0;
   // preset indices and reset values, in walk order
   logic [7:0]        idx [5] = '{`ECL_IDX_P1_SLOT, `ECL_IDX_P2_SLOT,
                         `ECL_IDX_P0_TL, `ECL_IDX_P1_TL, `ECL_IDX_P2_TL};
   logic [15:0]       defs [5] = '{`ECL_DEF_P1_SLOT, `ECL_DEF_P2_SLOT,
                         `ECL_DEF_P0_TL, `ECL_DEF_P1_TL, `ECL_DEF_P2_TL};
   // every bit set, none set, then mixed fields and port numbers
   logic [15:0]       pat [3][5] = '{'{5{16'hFFFF}}, '{5{16'h0000}},
                         '{16'hA5C3, 16'h5A3C, 16'h0155, 16'h02AA, 16'h0F0F}};
   logic [15:0]       zw [5] = '{5{16'h0000}};
   logic [31:0]       q;

   always #4 hclk = ~hclk;

   ecl_ahb_host host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
                      .htrans, .hwrite, .hsize, .hwdata, .tmo);
   ecl_loader uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
                   .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
                   .p1_slot_cfg, .p2_slot_cfg, .p0_tl_cfg, .p1_tl_cfg,
                   .p2_tl_cfg, .cfg_ready);

   // expected images, worked out from the bit layout of each word
   function automatic ecl_slot_cfg_t slot_exp(logic [15:0] w);
      return ecl_slot_cfg_t'({w[0], w[1], w[2], w[3], w[6:4], w[15:9]});
   endfunction : slot_exp
   function automatic ecl_tl_cfg_t tl_exp(logic [15:0] w);
      return ecl_tl_cfg_t'({w[0], w[1], w[2], w[4], w[5], w[6], w[8], w[9]});
   endfunction : tl_exp

   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // one compare task per kind of result
   task chk_word(input string what, input logic [31:0] e,
                 input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask : chk_word
   task chk_slot(input string what, input ecl_slot_cfg_t e, ecl_slot_cfg_t s);
      chk_word(what, 32'(e), 32'(s));
   endtask : chk_slot
   task chk_tl(input string what, input ecl_tl_cfg_t e, input ecl_tl_cfg_t s);
      chk_word(what, 32'(e), 32'(s));
   endtask : chk_tl

   // bus access wrappers; a timed-out wait closes the run
   task wr(input logic [31:0] a, input logic [31:0] d);
      host.access(1'b1, a, d, q);
      if (tmo) begin err_count++; tally_and_finish; end
   endtask : wr
   task rd_chk(input string what, input logic [31:0] a, input logic [31:0] e);
      host.access(1'b0, a, 32'h0, q);
      if (tmo) begin err_count++; tally_and_finish; end
      chk_word(what, e, q);
   endtask : rd_chk
   function automatic logic [31:0] ra(logic [7:0] i);
      return {22'h0, i, 2'b00};
   endfunction : ra

   // bounded wait for the walk to finish
   task wait_cfg;
      int n;
      for (n = 0; n < 20 && cfg_ready !== 1'b1; n++) @(posedge hclk);
      if (n == 20) begin err_count++; tally_and_finish; end
   endtask : wait_cfg

   // all five images against the words that fed them
   task chk_all(input logic [15:0] w [5]);
      chk_slot("p1_slot", slot_exp(w[0]), p1_slot_cfg);
      chk_slot("p2_slot", slot_exp(w[1]), p2_slot_cfg);
      chk_tl("p0_tl", tl_exp(w[2]), p0_tl_cfg);
      chk_tl("p1_tl", tl_exp(w[3]), p1_tl_cfg);
      chk_tl("p2_tl", tl_exp(w[4]), p2_tl_cfg);
   endtask : chk_all

   // reset, then defaults applied, presets and status read back
   task test_defaults;
      hresetn <= 1'b0;
      repeat (20) @(posedge hclk);
      chk_word("reset outs", 32'h4, {29'h0, hreadyout, hresp, cfg_ready});
      chk_all(zw);
      hresetn <= 1'b1;
      wait_cfg;
      chk_all(defs);
      for (int i = 0; i < 5; i++) rd_chk("preset", ra(idx[i]), 32'(defs[i]));
      rd_chk("status", ra(`ECL_IDX_STATUS), 32'h1);
      // a control write without bit 0 starts nothing
      wr(ra(`ECL_IDX_CTRL), 32'h0);
      rd_chk("ctrl", ra(`ECL_IDX_CTRL), 32'h0);
      chk_word("ready kept", 32'h1, {31'h0, cfg_ready});
      $display("test defaults done");
   endtask : test_defaults

   // new words stay unapplied until a reload walks them in
   task test_patterns;
      logic [15:0] cur [5];
      cur = defs;
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 5; i++) wr(ra(idx[i]), {16'hFFFF, pat[r][i]});
         chk_all(cur);
         wr(ra(`ECL_IDX_CTRL), 32'h1);
         rd_chk("busy", ra(`ECL_IDX_STATUS), 32'h2);
         wait_cfg;
         chk_all(pat[r]);
         for (int i = 0; i < 5; i++)
            rd_chk("rdback", ra(idx[i]), 32'(pat[r][i]));
         cur = pat[r];
      end
      // unmapped place takes nothing and reads zero
      wr(32'h0000_01FC, 32'hFFFF_FFFF);
      rd_chk("unmapped", 32'h0000_01FC, 32'h0);
      $display("test patterns done");
   endtask : test_patterns

   // main sequence; the second reset restores the preset defaults
   initial begin
      test_defaults;
      test_patterns;
      test_defaults;
      tally_and_finish;
   end
endmodule : tb_ecl_loader
